// file: pkg/adc_seq_pkg.sv
// constants, types and helpers shared by the sequencer and its link engine
package adc_seq_pkg;
  localparam int          CHAN_NUM     = 6;
  localparam int          WORD_BITS    = 14;
  localparam int          SLOT_CLKS    = 16;
  localparam int          FRAME_CLKS   = 96;
  localparam logic [2:0]  NAP_PULSES   = 3'h2;
  localparam logic [2:0]  SLEEP_PULSES = 3'h4;
  localparam logic [2:0]  PULSE_SAT    = 3'h7;
  localparam logic [2:0]  SEL_ALL      = 3'h5;
  localparam logic [2:0]  CHAN_ALL     = 3'h6;
  localparam logic [3:0]  MSB_POS      = 4'hD;
  localparam logic [3:0]  TAIL_POS     = 4'hE;
  localparam logic [3:0]  LAST_POS     = 4'hF;
  localparam logic [6:0]  CNT_RST      = 7'h00;
  localparam logic [2:0]  CHAN_RST     = 3'h1;

  typedef logic [CHAN_NUM-1:0][WORD_BITS-1:0] word_bank_t;

  // channel-count select to number of converted channels
  function automatic logic [2:0] chan_decode(input logic [2:0] sel);
    chan_decode = (sel >= SEL_ALL) ? CHAN_ALL : sel + 3'h1;
  endfunction : chan_decode

  // front end delivers offset binary; bipolar flips the msb into two's complement
  function automatic logic [WORD_BITS-1:0] result_code(input logic [WORD_BITS-1:0] s, input logic range_polarity_select);
    result_code = range_polarity_select ? {~s[WORD_BITS-1], s[WORD_BITS-2:0]} : s;
  endfunction : result_code
endpackage : adc_seq_pkg

// file: pkg/seq_link_if.sv
// carrier between the master-clock control and the serial-clock link engine
`timescale 1ns/1ns
interface seq_link_if;
  import adc_seq_pkg::*;
  word_bank_t  held;
  logic [2:0]  chan_cnt;
  logic        bipolar;
  logic        hold_tog;
  logic        done_tog;
  logic        sck_tog;
  logic        serial_out;
  logic        serial_oe;
  modport ctl (output held, chan_cnt, bipolar, hold_tog, input done_tog, sck_tog, serial_out, serial_oe);
  modport lnk (input held, chan_cnt, bipolar, hold_tog, output done_tog, sck_tog, serial_out, serial_oe);
endinterface : seq_link_if

// file: verilog/sample_stream_engine.sv
// serial-clock domain: conversion steps, result store and serial readout
`timescale 1ns/1ns
module sample_stream_engine
(
  input  wire logic i_sck,
  input  wire logic i_rst_b,
  seq_link_if.lnk   l
);
  import adc_seq_pkg::*;

  typedef struct packed
  {
    logic             tq1;
    logic             tq2;
    logic             tprev;
    logic             sck_tog;
    logic             done_tog;
    logic             active;
    logic             oe;
    logic             dout;
    logic [6:0]       cnt;
    logic [2:0]       nch;
    logic             range_polarity_select;
    word_bank_t       snap;
    word_bank_t       results;
  } lnk_t;

  lnk_t       st;
  lnk_t       next_st;
  logic       start;
  logic [6:0] bidx;
  logic [2:0] bslot;
  logic [3:0] bpos;

  assign start = st.tq2 ^ st.tprev;
  assign bidx  = st.cnt - 7'h01;
  assign bslot = bidx[6:4];
  assign bpos  = bidx[3:0];

  always_comb
  begin
    logic [6:0] idx;
    idx           = st.cnt;
    next_st       = st;
    next_st.tq1   = l.hold_tog;
    next_st.tq2   = st.tq1;
    next_st.tprev = st.tq2;
    next_st.sck_tog = ~st.sck_tog;
    if (start)
    begin
      // a new hold restarts the frame; previous results go out first
      next_st.active = 1'b1;
      next_st.snap   = st.results;
      next_st.nch    = l.chan_cnt;
      next_st.range_polarity_select    = l.bipolar;
      next_st.cnt    = 7'h01;
      next_st.oe     = 1'b1;
      next_st.dout   = st.results[0][MSB_POS];
    end
    else if (st.active)
    begin
      next_st.cnt  = idx + 7'h01;
      next_st.oe   = idx[3:0] < TAIL_POS;
      next_st.dout = next_st.oe ? st.snap[idx[6:4]][MSB_POS - idx[3:0]] : 1'b0;
      if (idx[3:0] == LAST_POS)
        next_st.results[idx[6:4]] = result_code(l.held[idx[6:4]], st.range_polarity_select);
      if (idx == {st.nch, 4'h0} - 7'h01)
      begin
        // this edge ends the frame and opens acquisition
        next_st.active   = 1'b0;
        next_st.oe       = 1'b0;
        next_st.done_tog = ~st.done_tog;
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign l.done_tog   = st.done_tog;
  assign l.sck_tog    = st.sck_tog;
  assign l.serial_out = st.dout;
  assign l.serial_oe  = st.oe;

  default clocking cb @(posedge i_sck); endclocking
  default disable iff (!i_rst_b);

  sequence s_frame_start;
    start;
  endsequence

  a_first_word_prev: assert property (s_frame_start |=> st.snap == $past(st.results) && st.dout == $past(st.results[0][13]))
    else $error("frame did not open with previous channel zero msb");
  a_bit_order_msb: assert property (st.oe |-> st.dout == st.snap[bslot][MSB_POS - bpos])
    else $error("serial bit out of msb-first order");
  a_tail_hiz: assert property (st.active && bpos >= TAIL_POS |-> !st.oe)
    else $error("serial output driven in slot tail");
  a_frame_length: assert property ($fell(st.active) |-> st.cnt == {st.nch, 4'h0})
    else $error("frame did not last sixteen clocks per channel");
  a_result_hold: assert property (!st.active && !start |=> $stable(st.results))
    else $error("stored result changed outside a conversion");
endmodule : sample_stream_engine

// file: verilog/simultaneous_adc_sequencer.sv
// six-channel simultaneous-sampling sequencer: hold, power modes, readout top
`timescale 1ns/1ns
module simultaneous_adc_sequencer
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_sck,
  input  wire logic                     i_convert_strobe,
  input  wire logic                     i_chan_count_msb,
  input  wire logic                     i_chan_count_mid,
  input  wire logic                     i_chan_count_lsb,
  input  wire logic                     i_range_polarity_select,
  input  wire adc_seq_pkg::word_bank_t  i_sample_word,
  output logic                          o_serial_result_out,
  output logic                          o_serial_result_oe,
  output logic                          o_nap,
  output logic                          o_sleep,
  output logic                          o_acquiring
);
  import adc_seq_pkg::*;

  if (WORD_BITS > SLOT_CLKS || FRAME_CLKS != CHAN_NUM * SLOT_CLKS)
    $error("word does not fit its slot or frame length is inconsistent");

  typedef struct packed
  {
    logic       c1;
    logic       c2;
    logic       c3;
    logic       s1;
    logic       s2;
    logic       s3;
    logic       d1;
    logic       d2;
    logic       d3;
    logic [2:0] chan_count_mid;
    logic [2:0] chan_count_msb;
    logic       bip1;
    logic       bip2;
    word_bank_t held;
    logic [2:0] cnt;
    logic       range_polarity_select;
    logic       hold_tog;
    logic       nap;
    logic       sleep;
    logic       acq;
    logic [2:0] pulses;
  } ctl_t;

  ctl_t        st;
  ctl_t        next_st;
  logic        convert_strobe_rise;
  logic        sck_evt;
  logic        done_evt;
  seq_link_if  link ();

  sample_stream_engine u_engine
  (
    .i_sck   (i_sck),
    .i_rst_b (i_rst_b),
    .l       (link.lnk)
  );

  // edge detects compare the second and third stage of each synchroniser
  assign convert_strobe_rise = st.c2 & ~st.c3;
  assign sck_evt   = st.s2 ^ st.s3;
  assign done_evt  = st.d2 ^ st.d3;

  always_comb
  begin
    logic [2:0] np;
    np           = (st.pulses == PULSE_SAT) ? PULSE_SAT : st.pulses + 3'h1;
    next_st      = st;
    next_st.c1   = i_convert_strobe;
    next_st.c2   = st.c1;
    next_st.c3   = st.c2;
    next_st.s1   = link.sck_tog;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.d1   = link.done_tog;
    next_st.d2   = st.d1;
    next_st.d3   = st.d2;
    next_st.chan_count_mid = {i_chan_count_msb, i_chan_count_mid, i_chan_count_lsb};
    next_st.chan_count_msb = st.chan_count_mid;
    next_st.bip1 = i_range_polarity_select;
    next_st.bip2 = st.bip1;
    if (convert_strobe_rise)
    begin
      // settings caught at the hold; host keeps them steady until read
      next_st.held     = i_sample_word;
      next_st.cnt      = chan_decode(st.chan_count_msb);
      next_st.range_polarity_select      = st.bip2;
      next_st.hold_tog = ~st.hold_tog;
      next_st.acq      = 1'b0;
    end
    if (done_evt)
      next_st.acq = 1'b1;
    if (sck_evt)
    begin
      // clock activity cancels the idle pattern and wakes the part
      next_st.pulses = 3'h0;
      next_st.nap    = 1'b0;
      next_st.sleep  = 1'b0;
    end
    else if (convert_strobe_rise)
    begin
      next_st.pulses = np;
      if (np >= SLEEP_PULSES)
      begin
        next_st.sleep = 1'b1;
        next_st.nap   = 1'b0;
      end
      else if (np >= NAP_PULSES)
        next_st.nap = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st     <= '0;
      st.cnt <= CHAN_RST;
    end
    else
      st <= next_st;
  end

  // held word is static while the link reads it; the toggle marks it fresh
  assign link.held     = st.held;
  assign link.chan_cnt = st.cnt;
  assign link.bipolar  = st.range_polarity_select;
  assign link.hold_tog = st.hold_tog;

  assign o_serial_result_out = link.serial_out;
  assign o_serial_result_oe  = link.serial_oe;
  assign o_nap               = st.nap;
  assign o_sleep             = st.sleep;
  assign o_acquiring         = st.acq;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_idle_strobe;
    convert_strobe_rise && !sck_evt;
  endsequence

  sequence s_hold_taken;
    ##1 ($changed(st.hold_tog) && st.held == $past(i_sample_word));
  endsequence

  a_hold_samples: assert property (convert_strobe_rise |-> s_hold_taken)
    else $error("convert rise did not hold all six inputs");
  a_count_decode: assert property (convert_strobe_rise |=> ($past(st.chan_count_msb) >= 3'h5) ? st.cnt == 3'h6 : st.cnt == $past(st.chan_count_msb) + 3'h1)
    else $error("channel count decode wrong");
  a_range_taken: assert property (convert_strobe_rise |=> st.range_polarity_select == $past(st.bip2))
    else $error("range select not captured at hold");
  a_nap_entry: assert property (s_idle_strobe and st.pulses == 3'h1 |=> st.nap && !st.sleep)
    else $error("second idle strobe did not enter nap");
  a_sleep_entry: assert property (s_idle_strobe and st.pulses >= 3'h3 |=> st.sleep && !st.nap)
    else $error("fourth idle strobe did not enter sleep");
  a_nap_not_early: assert property (s_idle_strobe and st.pulses == 3'h0 |=> !st.nap && !st.sleep)
    else $error("single strobe entered a power mode");
  a_wake_sck: assert property (sck_evt |=> !st.nap && !st.sleep)
    else $error("serial clock did not wake the part");
  a_acquire_window: assert property (done_evt |=> st.acq ##0 (convert_strobe_rise ##1 !st.acq or !convert_strobe_rise))
    else $error("acquisition window not opened at frame end");

  // hold state may only move on a synced convert rise
  sequence s_no_hold;
    !convert_strobe_rise;
  endsequence

  // neither a strobe nor clock activity: power state must sit still
  sequence s_quiet;
    !convert_strobe_rise && !sck_evt;
  endsequence

  a_held_steady: assert property (s_no_hold |=> $stable(st.held))
    else $error("held words moved without a convert rise");

  a_count_steady: assert property (s_no_hold |=> $stable(st.cnt))
    else $error("channel count moved without a convert rise");

  a_range_steady: assert property (s_no_hold |=> $stable(st.range_polarity_select))
    else $error("range setting moved without a convert rise");

  a_hold_tog_steady: assert property (s_no_hold |=> $stable(st.hold_tog))
    else $error("hold toggle moved without a convert rise");

  a_count_range: assert property (st.cnt >= 3'h1 && st.cnt <= 3'h6)
    else $error("channel count outside one to six");

  a_convert_strobe_once: assert property (convert_strobe_rise |=> !convert_strobe_rise)
    else $error("one strobe edge gave two holds");

  a_mode_excl: assert property (!(st.nap && st.sleep))
    else $error("nap and sleep both set");

  a_mode_steady: assert property (s_quiet |=> $stable({st.nap, st.sleep}))
    else $error("power mode moved with no strobe or clock");

  a_pulse_steady: assert property (s_quiet |=> $stable(st.pulses))
    else $error("idle strobe count moved with no strobe or clock");

  a_pulse_clear: assert property (sck_evt |=> st.pulses == 3'h0)
    else $error("clock activity did not clear idle strobe count");

  a_pulse_step: assert property (s_idle_strobe ##0 st.pulses != 3'h7 |=> st.pulses == $past(st.pulses) + 3'h1)
    else $error("idle strobe not counted");

  a_pulse_sat: assert property (s_idle_strobe ##0 st.pulses == 3'h7 |=> st.pulses == 3'h7)
    else $error("idle strobe count wrapped");

  a_nap_third: assert property (s_idle_strobe ##0 st.pulses == 3'h2 |=> st.nap && !st.sleep)
    else $error("third idle strobe left nap");

  a_sleep_more: assert property (s_idle_strobe ##0 st.sleep |=> st.sleep)
    else $error("further idle strobe left sleep");

  a_sleep_stays: assert property (st.sleep && !sck_evt |=> st.sleep)
    else $error("sleep left without clock activity");

  a_nap_stays: assert property (st.nap && s_quiet |=> st.nap)
    else $error("nap left without clock activity");

  a_nap_rise_cause: assert property ($rose(st.nap) |-> $past(convert_strobe_rise) && !$past(sck_evt))
    else $error("nap entered without an idle strobe");

  a_sleep_rise_cause: assert property ($rose(st.sleep) |-> $past(convert_strobe_rise) && $past(st.pulses) >= 3'h3)
    else $error("sleep entered before the fourth idle strobe");

  a_sleep_drops_nap: assert property ($rose(st.sleep) |-> !st.nap)
    else $error("nap still set on sleep entry");

  a_wake_order: assert property ($fell(st.sleep) |-> $past(sck_evt))
    else $error("sleep left without a clock pulse");

  a_nap_fall_cause: assert property ($fell(st.nap) |-> $past(sck_evt) || st.sleep)
    else $error("nap left without clock pulse or sleep entry");

  a_acq_stays: assert property (st.acq && !convert_strobe_rise |=> st.acq)
    else $error("acquisition ended without a convert rise");

  a_acq_no_early: assert property (!st.acq && !done_evt |=> !st.acq)
    else $error("acquisition began before frame end");

  a_acq_close: assert property (convert_strobe_rise && !done_evt |=> !st.acq)
    else $error("convert rise did not end acquisition");

  a_acq_set_wins: assert property (done_evt && convert_strobe_rise |=> st.acq)
    else $error("frame end lost against a convert rise");

  a_acq_rise_cause: assert property ($rose(st.acq) |-> $past(done_evt))
    else $error("acquisition rose without frame end");
endmodule : simultaneous_adc_sequencer

// file: bench/host_model.sv
// host controller model: convert strobe, serial clock and result capture
`timescale 1ns/1ns
module host_model
(
  input  wire logic i_mclk,
  input  wire logic i_serial_result_out,
  input  wire logic i_serial_result_oe,
  output logic      o_sck,
  output logic      o_convert_strobe
);
  logic bits[$];

  initial
  begin
    o_sck = 1'b0;
    o_convert_strobe = 1'b0;
  end

  // strobe held four master clocks so the three-flop sync cannot miss it
  task automatic convert();
    @(posedge i_mclk);
    #2 o_convert_strobe = 1'b1;
    repeat (4) @(posedge i_mclk);
    #2 o_convert_strobe = 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask : convert

  task automatic sck_pulse();
    o_sck = 1'b1;
    #7 o_sck = 1'b0;
    #8;
  endtask : sck_pulse

  // clock stands still outside frames; the first rise with the pin driven marks the start
  task automatic read_frame(input int n);
    int k;
    bit started;
    k = 0;
    started = 1'b0;
    bits.delete();
    // keep serial edges off the master clock edges
    #7;
    for (int i = 0; i < 16 * n + 8 && !(started && k == 16 * n); i++)
    begin
      sck_pulse();
      if (started)
        k++;
      if (i_serial_result_oe === 1'b1)
      begin
        bits.push_back(i_serial_result_out);
        if (!started)
          k = 1;
        started = 1'b1;
      end
    end
  endtask : read_frame
endmodule : host_model

// file: bench/simultaneous_adc_sequencer_tb.sv
// self-checking bench for the sequencer with a host model on the serial side
`timescale 1ns/1ns
`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module simultaneous_adc_sequencer_tb;
  import adc_seq_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic       sck;
  logic       strobe;
  logic [2:0] cnt_code;
  logic       polarity;
  word_bank_t words;
  logic       ser_out;
  logic       ser_oe;
  logic       nap;
  logic       sleep;
  logic       acq;
  logic [13:0] exp_store[6];
  int         num_errors = 0;
  int         comparisons = 0;

  simultaneous_adc_sequencer i_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_sck(sck), .i_convert_strobe(strobe),
    .i_chan_count_msb(cnt_code[2]), .i_chan_count_mid(cnt_code[1]), .i_chan_count_lsb(cnt_code[0]),
    .i_range_polarity_select(polarity), .i_sample_word(words), .o_serial_result_out(ser_out),
    .o_serial_result_oe(ser_oe), .o_nap(nap), .o_sleep(sleep), .o_acquiring(acq));
  host_model i_host (.i_mclk(mclk), .i_serial_result_out(ser_out), .i_serial_result_oe(ser_oe),
    .o_sck(sck), .o_convert_strobe(strobe));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // one conversion: words differ per channel so order and simultaneity show
  task automatic run_frame(input logic [2:0] code, input logic pol, input logic [15:0] frame);
    int n;
    logic [13:0] w;
    n = (code >= 3'h5) ? 6 : int'(code) + 1;
    @(posedge mclk);
    #2 cnt_code = code;
    polarity = pol;
    for (int ch = 0; ch < 6; ch++)
      words[ch] = 14'(16'h1F3B * 16'(ch + 1) + frame * 16'h0911);
    i_host.convert();
    `CHECK(acq, 1'b0, "acquiring during conversion")
    i_host.read_frame(n);
    `CHECK(i_host.bits.size(), 14 * n, "result bit count")
    for (int ch = 0; ch < n; ch++)
      for (int b = 0; b < 14; b++)
        `CHECK(i_host.bits[ch * 14 + b], exp_store[ch][13 - b], "result bit")
    for (int ch = 0; ch < n; ch++)
    begin
      w = words[ch];
      exp_store[ch] = pol ? {~w[13], w[12:0]} : w;
    end
    repeat (5) @(posedge mclk);
    `CHECK(acq, 1'b1, "acquisition after last clock")
    `CHECK(ser_oe, 1'b0, "pin released after frame")
    `CHECK(ser_out, 1'b0, "pin data low while released")
  endtask : run_frame

  task automatic power_modes();
    i_host.convert();
    i_host.convert();
    `CHECK({nap, sleep}, 2'h2, "nap after two strobes")
    i_host.convert();
    i_host.convert();
    `CHECK({nap, sleep}, 2'h1, "sleep after four strobes")
    #7 i_host.sck_pulse();
    repeat (5) @(posedge mclk);
    `CHECK({nap, sleep}, 2'h0, "wake on clock pulse")
  endtask : power_modes

  initial
  begin
    #600000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    rst_b = 1'b0;
    cnt_code = 3'h0;
    polarity = 1'b0;
    words = '0;
    for (int ch = 0; ch < 6; ch++)
      exp_store[ch] = 14'h0000;
    repeat (3) @(posedge mclk);
    #2 rst_b = 1'b1;
    `CHECK({ser_oe, nap, sleep, acq}, 4'h0, "outputs after reset")
    run_frame(3'h5, 1'b0, 16'h0001);
    run_frame(3'h5, 1'b0, 16'h0002);
    run_frame(3'h5, 1'b1, 16'h0003);
    run_frame(3'h5, 1'b1, 16'h0004);
    run_frame(3'h1, 1'b1, 16'h0005);
    run_frame(3'h0, 1'b1, 16'h0006);
    run_frame(3'h3, 1'b0, 16'h0007);
    run_frame(3'h2, 1'b0, 16'h0008);
    run_frame(3'h4, 1'b0, 16'h0009);
    run_frame(3'h6, 1'b0, 16'h000A);
    run_frame(3'h7, 1'b0, 16'h000B);
    power_modes();
    end_sim();
  end
endmodule : simultaneous_adc_sequencer_tb
